/* File: rtl/byte_reorder.sv */
`timescale 1ns/1ps
module byte_reorder (
  // Selection
  input  wire dma_crc_pkg::byte_order_t order,
  // Data
  input  wire logic [31:0]              data_in,
  output logic      [31:0]              data_out
);
  import dma_crc_pkg::*;

  always_comb begin
    case (order)
      order_none:       data_out = data_in;
      order_word_bytes: data_out = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
      order_halfwords:  data_out = {data_in[15:0], data_in[31:16]};
      order_half_bytes: data_out = {data_in[23:16], data_in[31:24], data_in[7:0], data_in[15:8]};
      default:          data_out = data_in;
    endcase
  end

endmodule : byte_reorder

/* File: rtl/crc_engine.sv */
`timescale 1ns/1ps
`include "dma_crc_regs.svh"
module crc_engine #(
  parameter logic [31:0] POLY_TAPS = 32'h0000_0007
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Configuration
  input  wire dma_crc_pkg::crc_control_t control,
  // Seed load
  input  wire logic                      seed_load,
  input  wire logic [31:0]               seed_value,
  // Data feed
  input  wire logic                      feed_valid,
  input  wire logic [31:0]               feed_data,
  // Result
  output logic      [31:0]               crc_value
);
  import dma_crc_pkg::*;

  logic [31:0] state;
  logic [31:0] length_mask;
  logic [31:0] feed_bits;
  logic [31:0] next_state;
  logic [16:0] sum_lo;
  logic [16:0] sum_hi;

  always_comb begin
    length_mask = 32'hFFFF_FFFF >> (5'd31 - control.polynomial_length_minus_one);
    feed_bits   = control.bit_order_select ? {<<{feed_data}} : feed_data;
  end

  always_comb begin
    next_state = state;
    sum_lo     = 17'h0_0000;
    sum_hi     = 17'h0_0000;
    if (control.checksum_type_select) begin
      sum_lo     = {1'b0, state[15:0]} + {1'b0, feed_bits[15:0]};
      sum_lo     = {1'b0, sum_lo[15:0]} + {16'h0000, sum_lo[16]};
      sum_hi     = {1'b0, sum_lo[15:0]} + {1'b0, feed_bits[31:16]};
      sum_hi     = {1'b0, sum_hi[15:0]} + {16'h0000, sum_hi[16]};
      next_state = {16'h0000, sum_hi[15:0]};
    end else begin
      for (int i = 31; i >= 0; i--) begin
        if (next_state[control.polynomial_length_minus_one] ^ feed_bits[i]) begin
          next_state = ((next_state << 1) ^ POLY_TAPS) & length_mask;
        end else begin
          next_state = (next_state << 1) & length_mask;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= `RESET_WORD;
    end else if (seed_load) begin
      state <= control.checksum_type_select ? {16'h0000, ~seed_value[15:0]}
                                            : seed_value & length_mask;
    end else if (feed_valid) begin
      state <= next_state;
    end
  end

  always_comb begin
    crc_value = control.checksum_type_select ? {16'h0000, ~state[15:0]} : state & length_mask;
  end

endmodule : crc_engine

/* File: rtl/dma_crc_config_status.sv */
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dma_crc_regs.svh"
module dma_crc_config_status #(
  parameter logic [31:0] POLY_TAPS = 32'h0000_0007
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  // DMA engine state
  input  wire logic                 module_enable,
  input  wire logic                 transfer_active,
  // DMA bus access report
  input  wire logic                 access_valid,
  input  wire dma_crc_pkg::access_t access_info,
  // Channel source data
  input  wire dma_crc_pkg::beat_t   source_beat,
  input  wire logic                 block_done,
  input  wire logic [2:0]           block_channel,
  // Destination data
  output dma_crc_pkg::beat_t        dest_beat,
  output logic                      dest_is_crc,
  // CRC configuration seen by the DMA engine
  output dma_crc_pkg::crc_control_t crc_config,
  output logic                      crc_routed
);
  import dma_crc_pkg::*;

  typedef enum logic [1:0] {
    xfer_idle,
    xfer_feed,
    xfer_result
  } xfer_state_t;

  crc_control_t control;
  access_t      last_access;
  logic         module_busy_flag;
  xfer_state_t  xfer_state;
  xfer_state_t  next_xfer_state;
  logic [31:0]  reordered;
  logic [31:0]  crc_value;
  logic         selected_beat;
  logic         feed_valid;
  logic         seed_load;
  logic         write_crc_control;
  logic [31:0]  next_rdata;

  // Register write decode
  always_comb begin
    write_crc_control = reg_write && (reg_addr == `OFS_CRC_CONTROL);
    seed_load         = reg_write && (reg_addr == `OFS_CRC_DATA);
  end

  // Module busy indication
  always_ff @(posedge clk) begin
    if (reset) begin
      module_busy_flag <= 1'b0;
    end else begin
      module_busy_flag <= module_enable || transfer_active;
    end
  end

  // Last access record, all fields captured as one
  always_ff @(posedge clk) begin
    if (reset) begin
      last_access <= access_t'(0);
    end else if (access_valid) begin
      last_access <= access_info;
    end
  end

  // CRC control register
  always_ff @(posedge clk) begin
    if (reset) begin
      control <= crc_control_t'(0);
    end else if (write_crc_control) begin
      control.byte_order_select <=
        byte_order_t'(reg_wdata[`POS_BYTE_ORDER +: 2]);
      control.write_byte_order            <= reg_wdata[`BIT_WRITE_ORDER];
      control.bit_order_select            <= reg_wdata[`BIT_BIT_ORDER];
      control.polynomial_length_minus_one <= reg_wdata[`POS_POLY_LENGTH +: 5];
      control.checksum_enable             <= reg_wdata[`BIT_CRC_ENABLE];
      control.append_mode                 <=
        reg_wdata[`BIT_APPEND_MODE] && !reg_wdata[`BIT_WRITE_ORDER];
      control.checksum_type_select        <= reg_wdata[`BIT_TYPE_SELECT];
      control.checksum_channel_select     <= reg_wdata[`POS_CHANNEL_SELECT +: 3];
    end
  end

  always_comb begin
    crc_config = control;
    crc_routed = control.checksum_enable;
  end

  // Byte reordering of the source word
  byte_reorder u_reorder (
    .order    (control.byte_order_select),
    .data_in  (source_beat.data),
    .data_out (reordered)
  );

  // Only the attached channel feeds the engine
  always_comb begin
    selected_beat = source_beat.valid && control.checksum_enable
                    && (source_beat.channel == control.checksum_channel_select);
    feed_valid    = selected_beat && !seed_load;
  end

  crc_engine #(
    .POLY_TAPS (POLY_TAPS)
  ) u_engine (
    .clk        (clk),
    .reset      (reset),
    .control    (control),
    .seed_load  (seed_load),
    .seed_value (reg_wdata),
    .feed_valid (feed_valid),
    .feed_data  (reordered),
    .crc_value  (crc_value)
  );

  // Transfer sequencing for append mode
  always_comb begin
    next_xfer_state = xfer_state;
    case (xfer_state)
      xfer_idle: begin
        if (selected_beat && control.append_mode) begin
          next_xfer_state = xfer_feed;
        end
      end
      xfer_feed: begin
        if (!control.checksum_enable || !control.append_mode) begin
          next_xfer_state = xfer_idle;
        end else if (block_done
                     && block_channel == control.checksum_channel_select) begin
          next_xfer_state = xfer_result;
        end
      end
      xfer_result: begin
        next_xfer_state = xfer_idle;
      end
      default: begin
        next_xfer_state = xfer_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xfer_state <= xfer_idle;
    end else begin
      xfer_state <= next_xfer_state;
    end
  end

  // Destination data path
  always_ff @(posedge clk) begin
    if (reset) begin
      dest_beat   <= beat_t'(0);
      dest_is_crc <= 1'b0;
    end else if (xfer_state == xfer_result) begin
      dest_beat.valid   <= 1'b1;
      dest_beat.channel <= control.checksum_channel_select;
      dest_beat.data    <= crc_value;
      dest_is_crc       <= 1'b1;
    end else if (selected_beat && control.append_mode) begin
      dest_beat.valid <= 1'b0;
      dest_is_crc     <= 1'b0;
    end else begin
      dest_beat.valid   <= source_beat.valid;
      dest_beat.channel <= source_beat.channel;
      dest_beat.data    <= (selected_beat && control.write_byte_order)
                           ? reordered : source_beat.data;
      dest_is_crc       <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = `RESET_WORD;
    case (reg_addr)
      `OFS_GLOBAL_CONTROL: begin
        next_rdata[`BIT_MODULE_BUSY] = module_busy_flag;
      end
      `OFS_STATUS: begin
        next_rdata[`BIT_LAST_DIRECTION] = last_access.read;
        next_rdata[2:0]                 = last_access.channel;
      end
      `OFS_LAST_ADDRESS: begin
        next_rdata = last_access.address;
      end
      `OFS_CRC_CONTROL: begin
        next_rdata[`POS_BYTE_ORDER +: 2]     = control.byte_order_select;
        next_rdata[`BIT_WRITE_ORDER]         = control.write_byte_order;
        next_rdata[`BIT_BIT_ORDER]           = control.bit_order_select;
        next_rdata[`POS_POLY_LENGTH +: 5]    = control.polynomial_length_minus_one;
        next_rdata[`BIT_CRC_ENABLE]          = control.checksum_enable;
        next_rdata[`BIT_APPEND_MODE]         = control.append_mode;
        next_rdata[`BIT_TYPE_SELECT]         = control.checksum_type_select;
        next_rdata[`POS_CHANNEL_SELECT +: 3] = control.checksum_channel_select;
      end
      `OFS_CRC_DATA: begin
        next_rdata = crc_value;
      end
      default: begin
        next_rdata = `RESET_WORD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `RESET_WORD;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `RESET_WORD;
    end
  end

endmodule : dma_crc_config_status

/* File: rtl/dma_crc_pkg.sv */
package dma_crc_pkg;

  typedef enum logic [1:0] {
    order_none,
    order_word_bytes,
    order_halfwords,
    order_half_bytes
  } byte_order_t;

  typedef struct packed {
    byte_order_t byte_order_select;
    logic        write_byte_order;
    logic        bit_order_select;
    logic [4:0]  polynomial_length_minus_one;
    logic        checksum_enable;
    logic        append_mode;
    logic        checksum_type_select;
    logic [2:0]  checksum_channel_select;
  } crc_control_t;

  typedef struct packed {
    logic        read;
    logic [2:0]  channel;
    logic [31:0] address;
  } access_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  channel;
    logic [31:0] data;
  } beat_t;

endpackage : dma_crc_pkg

/* File: rtl/dma_crc_regs.svh */
`ifndef DMA_CRC_REGS_SVH
`define DMA_CRC_REGS_SVH

`define OFS_GLOBAL_CONTROL  8'h00
`define OFS_STATUS          8'h10
`define OFS_LAST_ADDRESS    8'h20
`define OFS_CRC_CONTROL     8'h30
`define OFS_CRC_DATA        8'h40

`define BIT_MODULE_BUSY     11
`define BIT_LAST_DIRECTION  3
`define POS_BYTE_ORDER      28
`define BIT_WRITE_ORDER     27
`define BIT_BIT_ORDER       24
`define POS_POLY_LENGTH     8
`define BIT_CRC_ENABLE      7
`define BIT_APPEND_MODE     6
`define BIT_TYPE_SELECT     5
`define POS_CHANNEL_SELECT  0

`define RESET_WORD          32'h0000_0000

`endif

/* File: verif/dma_crc_config_status_assertions.sv */
`timescale 1ns/1ps
module dma_crc_checker (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      reset,
  // Register port
  input wire logic [7:0]                reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_write,
  input wire logic                      reg_read,
  input wire logic [31:0]               reg_rdata,
  // DMA side
  input wire logic                      module_enable,
  input wire logic                      transfer_active,
  input wire logic                      access_valid,
  input wire dma_crc_pkg::access_t      access_info,
  input wire dma_crc_pkg::beat_t        source_beat,
  input wire logic                      block_done,
  input wire logic [2:0]                block_channel,
  input wire dma_crc_pkg::beat_t        dest_beat,
  input wire logic                      dest_is_crc,
  input wire dma_crc_pkg::crc_control_t crc_config,
  input wire logic                      crc_routed
);
  import dma_crc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence busy_s(logic b);
    ((module_enable || transfer_active) == b) [*2] ##0 (reg_read && reg_addr == 8'h00);
  endsequence
  sequence acc_rd_s(logic [7:0] a);
    reg_read && !access_valid && reg_addr == a;
  endsequence

  access_t seen_access;

  // Reference copy of the last reported access
  always_ff @(posedge clk) begin
    if (reset) begin
      seen_access <= access_t'(0);
    end else if (access_valid) begin
      seen_access <= access_info;
    end
  end

  busy_set_a: assert property (busy_s(1'h1) |=> reg_rdata == 32'h0000_0800)
    else $error("busy flag not reported");
  busy_clear_a: assert property (busy_s(1'h0) |=> reg_rdata == 32'h0)
    else $error("busy flag set while idle");
  status_zero_a: assert property (reg_read && reg_addr == 8'h10 |=> reg_rdata[31:4] == 28'h0)
    else $error("status upper bits not zero");
  access_addr_a: assert property (acc_rd_s(8'h20) |=> reg_rdata == seen_access.address)
    else $error("last address wrong");
  access_status_a: assert property (acc_rd_s(8'h10) |=>
    reg_rdata[3:0] == {seen_access.read, seen_access.channel})
    else $error("direction or channel wrong");
  append_lock_a: assert property (crc_config.write_byte_order |-> !crc_config.append_mode)
    else $error("append set with write order");
  ctrl_write_a: assert property (reg_write && reg_addr == 8'h30 |=>
    crc_config.checksum_channel_select == $past(reg_wdata[2:0]) &&
    crc_config.polynomial_length_minus_one == $past(reg_wdata[12:8]))
    else $error("control write not stored");
  routed_a: assert property (crc_routed == crc_config.checksum_enable)
    else $error("routing does not follow enable");
  pass_thru_a: assert property (source_beat.valid && !crc_config.checksum_enable |=>
    dest_beat.valid && dest_beat.data == $past(source_beat.data))
    else $error("plain beat not passed");
  append_drop_a: assert property (source_beat.valid && crc_config.checksum_enable &&
    crc_config.append_mode && source_beat.channel == crc_config.checksum_channel_select
    |=> !dest_beat.valid) else $error("append beat reached destination");
  crc_result_a: assert property (block_done && crc_config.checksum_enable &&
    crc_config.append_mode && block_channel == crc_config.checksum_channel_select
    |-> ##2 (dest_is_crc && dest_beat.valid)) else $error("result not written");
endmodule : dma_crc_checker

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import dma_crc_pkg::*;
  logic         clk = 1'h0;
  logic         reset = 1'h1;
  logic [7:0]   reg_addr = 8'h00;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_write = 1'h0;
  logic         reg_read = 1'h0;
  logic [31:0]  reg_rdata;
  logic         module_enable = 1'h0;
  logic         transfer_active = 1'h0;
  logic         access_valid = 1'h0;
  access_t      access_info = '0;
  beat_t        source_beat = '0;
  logic         block_done = 1'h0;
  logic [2:0]   block_channel = 3'h0;
  beat_t        dest_beat;
  logic         dest_is_crc;
  crc_control_t crc_config;
  logic         crc_routed;
  int           error_cnt = 0;
  int           total_checks = 0;
  int           i;
  logic [31:0]  swapped [4] = '{32'h1122_3344, 32'h4433_2211, 32'h3344_1122, 32'h2211_4433};

  always #5 clk = ~clk;

  dma_crc_config_status i_dut (.*);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clk);
    reg_read <= 1'h0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  task automatic acc(input logic r, input logic [2:0] ch, input logic [31:0] a);
    @(posedge clk);
    access_valid <= 1'h1;
    access_info  <= {r, ch, a};
    @(posedge clk);
    access_valid <= 1'h0;
  endtask : acc

  task automatic beat(input logic [2:0] ch, input logic [31:0] d, input logic v,
                      input logic [31:0] exp);
    @(posedge clk);
    source_beat <= {1'h1, ch, d};
    @(posedge clk);
    source_beat <= '0;
    #1 chk("dest valid", {31'h0, v}, {31'h0, dest_beat.valid});
    if (v) chk("dest data", exp, dest_beat.data);
  endtask : beat

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h30, 32'h0);
    @(posedge clk);
    module_enable <= 1'h1;
    rd(8'h00, 32'h0000_0800);
    @(posedge clk);
    module_enable   <= 1'h0;
    transfer_active <= 1'h1;
    rd(8'h00, 32'h0000_0800);
    @(posedge clk);
    transfer_active <= 1'h0;
    repeat (2) @(posedge clk);
    rd(8'h00, 32'h0);
    acc(1'h1, 3'h5, 32'hA5C3_0F12);
    rd(8'h10, 32'h0000_000D);
    rd(8'h20, 32'hA5C3_0F12);
    acc(1'h0, 3'h2, 32'h0000_0FF0);
    rd(8'h10, 32'h0000_0002);
    rd(8'h20, 32'h0000_0FF0);
    wr(8'h10, 32'hFFFF_FFFF);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0002);
    rd(8'h20, 32'h0000_0FF0);
    rd(8'h50, 32'h0);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h3900_1FA7);
    chk("crc_routed", 32'h1, {31'h0, crc_routed});
    wr(8'h30, 32'h0000_0040);
    rd(8'h30, 32'h0000_0040);
    for (i = 0; i < 4; i++) begin
      wr(8'h30, {2'h0, i[1:0], 28'h800_0085});
      beat(3'h5, 32'h1122_3344, 1'h1, swapped[i]);
      beat(3'h4, 32'h1122_3344, 1'h1, 32'h1122_3344);
    end
    wr(8'h30, 32'h3000_0085);
    beat(3'h5, 32'h1122_3344, 1'h1, 32'h1122_3344);
    wr(8'h30, 32'h0000_0700);
    wr(8'h40, 32'h1234_56AB);
    rd(8'h40, 32'h0000_00AB);
    wr(8'h30, 32'h0000_0020);
    wr(8'h40, 32'h1234_ABCD);
    rd(8'h40, 32'h0000_ABCD);
    wr(8'h30, 32'h0000_1F00);
    wr(8'h40, 32'hCAFE_0001);
    rd(8'h40, 32'hCAFE_0001);
    beat(3'h6, 32'h0102_0304, 1'h1, 32'h0102_0304);
    wr(8'h30, 32'h0000_00A0);
    wr(8'h40, 32'h0000_0000);
    beat(3'h0, 32'h0001_0002, 1'h1, 32'h0001_0002);
    rd(8'h40, 32'h0000_FFFC);
    wr(8'h30, 32'h0100_00A0);
    wr(8'h40, 32'h0000_0000);
    beat(3'h0, 32'h0001_0002, 1'h1, 32'h0001_0002);
    rd(8'h40, 32'h0000_3FFF);
    wr(8'h30, 32'h0000_0780);
    wr(8'h40, 32'h0000_0000);
    beat(3'h0, 32'h0000_0001, 1'h1, 32'h0000_0001);
    rd(8'h40, 32'h0000_0007);
    wr(8'h30, 32'h0100_0780);
    wr(8'h40, 32'h0000_0000);
    beat(3'h0, 32'h8000_0000, 1'h1, 32'h8000_0000);
    rd(8'h40, 32'h0000_0007);
    wr(8'h30, 32'h0000_00C3);
    beat(3'h3, 32'h0F0F_0F0F, 1'h0, 32'h0);
    beat(3'h1, 32'h5566_7788, 1'h1, 32'h5566_7788);
    @(posedge clk);
    block_done    <= 1'h1;
    block_channel <= 3'h3;
    @(posedge clk);
    block_done <= 1'h0;
    @(posedge clk);
    #1 chk("dest_is_crc", 32'h1, {31'h0, dest_is_crc});
    chk("dest valid", 32'h1, {31'h0, dest_beat.valid});
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : tb

bind dma_crc_config_status dma_crc_checker i_chk (.*);
